// ---- inc/valve_io_pkg.sv ----
package valve_io_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	localparam int unsigned STABLE_MS = 30;
	localparam int unsigned STABLE_CYCLES = STABLE_MS * CLK_PER_MS;
	localparam int unsigned MS_TICK_CYCLES = CLK_PER_MS;
	localparam int unsigned OFF_STEP_MS = 5;
	localparam int unsigned OFF_ROUND_MS = 3;
	localparam logic [15:0] OFF_DELAY_MAX_MS = 16'h7530;

	// ----------------------------------------
	// reset values and mode codes
	// ----------------------------------------
	localparam logic [2:0] MODE_RST = 3'h1;
	localparam logic [2:0] MODE_MIN = 3'h1;
	localparam logic [2:0] MODE_MAX = 3'h4;
	localparam logic [2:0] MODE_DUAL = 3'h1;
	localparam logic [2:0] MODE_TOGGLE = 3'h2;
	localparam logic [2:0] MODE_STATE_LO_EN = 3'h3;
	localparam logic [15:0] RET_DELAY_RST = 16'h0064;
	localparam logic [15:0] OFF_DELAY_RST = 16'h0000;

	// ----------------------------------------
	// register offsets and status fields
	// ----------------------------------------
	localparam logic [11:0] MODE_OFF = 12'h000;
	localparam logic [11:0] RET_DELAY_OFF = 12'h004;
	localparam logic [11:0] OFF_DELAY_OFF = 12'h008;
	localparam logic [11:0] STATUS_OFF = 12'h00C;
	localparam int unsigned ST_POS_B_BIT = 0;
	localparam int unsigned ST_VALID_BIT = 1;
	localparam int unsigned ST_ERR_BIT = 2;
	localparam int unsigned ST_BUSY_BIT = 3;
	localparam int unsigned ST_IN1_BIT = 4;
	localparam int unsigned ST_IN2_BIT = 5;
	localparam int unsigned ST_SHOW_BIT = 6;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MOVE,
		ST_HOLD
	} move_st_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// ---- core/input_filter.sv ----
module input_filter
	import valve_io_pkg::*;
#(
	parameter int unsigned STABLE_CYC = STABLE_CYCLES,
	parameter int unsigned CNT_W = 21
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw pin and filtered level
	input wire logic raw_n,
	output logic stable_n
);

	logic sync1_ff;
	logic sync2_ff;
	logic stable_ff;
	logic [CNT_W-1:0] cnt_ff;

	// ----------------------------------------
	// synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
		end else begin
			sync1_ff <= raw_n; // [R19]
			sync2_ff <= sync1_ff; // [R19]
		end
	end

	// ----------------------------------------
	// stability filter
	// ----------------------------------------
	// any glitch back to the old level restarts the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			stable_ff <= 1'b1;
		end else if (sync2_ff == stable_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff == CNT_W'(STABLE_CYC - 1)) begin
			cnt_ff <= '0;
			stable_ff <= sync2_ff; // [R6]
		end else begin
			cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end

	assign stable_n = stable_ff;

endmodule

// ---- core/valve_position_discrete_io.sv ----
// Operation
// [R1] all pins are active low: low asserted, high deasserted.
// [R2] at position A: A output low, A relay closed, B high and open.
// [R3] at position B: B output low, B relay closed, A high and open.
// [R4] A and B indication sets are never asserted together.
// [R5] positioning error: both outputs high and both relays open.
// [R6] input change accepted only after 30 ms stable; driver holds that long.
// [R7] held or reasserted input without recognised release gives no new move.
// [R8] input mode 1 to 4 set by software, mode 1 after reset.
// [R9] mode change does not alter indication output behaviour.
// [R10] mode 1: first input moves to A, second input moves to B.
// [R11] mode 1: both inputs asserted together are ignored.
// [R12] mode 2: first input toggles to the opposite position.
// [R13] mode 2: second input toggles, waits return delay, then returns.
// [R14] modes 3 and 4: first input low commands A, high commands B.
// [R15] mode 3: moves allowed only while second input held low.
// [R16] mode 4: moves allowed while second input high, blocked while low.
// [R17] return delay programmable 0 to 65535 ms.
// [R18] indication off after 0 to 30000 ms in 5 ms steps; zero keeps on.
// [R19] inputs pass two synchroniser flops before filtering.
// [R20] error indication holds until next successful move restores position.
//
// The APB slave port and the register offsets are this design's own decisions.
module valve_position_discrete_io
	import valve_io_pkg::*;
#(
	parameter int unsigned STABLE_CYC = STABLE_CYCLES,
	parameter int unsigned MS_CYC = MS_TICK_CYCLES,
	parameter int unsigned FILT_W = 21,
	parameter int unsigned TICK_W = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire apb_req_t apb_req,
	output apb_rsp_t apb_rsp,
	// discrete command inputs, active low
	input wire logic cmd_in1_n,
	input wire logic cmd_in2_n,
	// motor sequencer handshake
	output logic move_req,
	output logic move_to_b,
	input wire logic move_done,
	input wire logic move_fault,
	// position indication, active low
	output logic pos_a_out_n,
	output logic pos_b_out_n,
	output logic relay_a_close_n,
	output logic relay_b_close_n
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [1:0] raw_n, filt_n, asrt, asrt_prev_ff, ev;
	logic [2:0] mode_ff, step_cnt_ff;
	logic [15:0] ret_delay_ff, off_delay_ff, hold_ms_ff, elapsed_ff;
	logic [TICK_W-1:0] tick_cnt_ff;
	logic [31:0] status;
	apb_rsp_t rsp_ff;
	move_st_t st_ff;
	logic ms_tick, move_req_ff, target_b_ff, origin_b_ff, ret_pend_ff;
	logic pos_b_ff, valid_ff, err_ff, show_ff, last_lvl_b_ff, en_prev_ff;
	logic lvl_en, lvl_b, go, go_b, go_ret, indicate, wr_acc, rd_setup;
	logic pos_a_n_ff, pos_b_n_ff, rel_a_n_ff, rel_b_n_ff;

	// ----------------------------------------
	// input filtering
	// ----------------------------------------
	assign raw_n = {cmd_in2_n, cmd_in1_n};
	for (genvar i = 0; i < 2; i++) begin : g_in
		input_filter #(.STABLE_CYC(STABLE_CYC), .CNT_W(FILT_W)) input_filter_inst (
			.pclk(pclk), .presetn(presetn), .raw_n(raw_n[i]), .stable_n(filt_n[i]));
	end
	assign asrt = ~filt_n; // [R1]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asrt_prev_ff <= 2'h0;
		end else begin
			asrt_prev_ff <= asrt;
		end
	end
	// edge only after a recognised release, so a held input is inert
	assign ev = asrt & ~asrt_prev_ff; // [R7]

	// ----------------------------------------
	// millisecond tick
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= '0;
		end else if (tick_cnt_ff == TICK_W'(MS_CYC - 1)) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
		end
	end
	assign ms_tick = (tick_cnt_ff == TICK_W'(MS_CYC - 1));

	// ----------------------------------------
	// move request decode
	// ----------------------------------------
	assign lvl_b = ~asrt[0]; // [R14]
	assign lvl_en = (mode_ff == MODE_STATE_LO_EN) ? asrt[1] : ~asrt[1]; // [R15] [R16]
	always_comb begin
		go = 1'b0;
		go_b = pos_b_ff;
		go_ret = 1'b0;
		if (mode_ff == MODE_DUAL) begin
			if (ev[0] && !asrt[1]) begin // [R10] [R11]
				go = 1'b1;
				go_b = 1'b0;
			end else if (ev[1] && !asrt[0]) begin // [R10] [R11]
				go = 1'b1;
				go_b = 1'b1;
			end
		end else if (mode_ff == MODE_TOGGLE) begin
			if (ev[0]) begin // [R12]
				go = 1'b1;
				go_b = ~pos_b_ff;
			end else if (ev[1]) begin // [R13]
				go = 1'b1;
				go_b = ~pos_b_ff;
				go_ret = 1'b1;
			end
		end else begin
			// a new level or a fresh enable starts a move; no retry loop on faults
			if (lvl_en && (lvl_b != last_lvl_b_ff || !en_prev_ff)) begin // [R14] [R15] [R16]
				go = 1'b1;
				go_b = lvl_b;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_lvl_b_ff <= 1'b0;
			en_prev_ff <= 1'b0;
		end else if (st_ff == ST_IDLE) begin
			en_prev_ff <= lvl_en;
			if (go) begin
				last_lvl_b_ff <= go_b;
			end
		end
	end

	// ----------------------------------------
	// move sequencer
	// ----------------------------------------
	// edge requests that arrive while busy are dropped; a level changed meanwhile in modes 3 and 4 moves once idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_IDLE;
			move_req_ff <= 1'b0;
			target_b_ff <= 1'b0;
			origin_b_ff <= 1'b0;
			ret_pend_ff <= 1'b0;
			hold_ms_ff <= 16'h0000;
		end else begin
			move_req_ff <= 1'b0;
			case (st_ff)
				ST_IDLE: begin
					if (go) begin
						move_req_ff <= 1'b1;
						target_b_ff <= go_b;
						origin_b_ff <= pos_b_ff;
						ret_pend_ff <= go_ret;
						st_ff <= ST_MOVE;
					end
				end
				ST_MOVE: begin
					if (move_fault) begin
						ret_pend_ff <= 1'b0;
						st_ff <= ST_IDLE;
					end else if (move_done) begin
						hold_ms_ff <= 16'h0000;
						st_ff <= ret_pend_ff ? ST_HOLD : ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (hold_ms_ff == ret_delay_ff) begin // [R13] [R17]
						move_req_ff <= 1'b1;
						target_b_ff <= origin_b_ff;
						ret_pend_ff <= 1'b0;
						st_ff <= ST_MOVE;
					end else if (ms_tick) begin
						hold_ms_ff <= hold_ms_ff + 16'h0001;
					end
				end
				default: begin
					st_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// position and error state
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_b_ff <= 1'b0;
			valid_ff <= 1'b0;
			err_ff <= 1'b0;
		end else if (st_ff == ST_MOVE && move_fault) begin
			valid_ff <= 1'b0;
			err_ff <= 1'b1; // [R5]
		end else if (st_ff == ST_MOVE && move_done) begin
			pos_b_ff <= target_b_ff;
			valid_ff <= 1'b1;
			err_ff <= 1'b0; // [R20]
		end
	end

	// ----------------------------------------
	// indication off timer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			show_ff <= 1'b0;
			step_cnt_ff <= 3'h0;
			elapsed_ff <= 16'h0000;
		end else if (st_ff == ST_MOVE && move_done) begin
			show_ff <= 1'b1;
			step_cnt_ff <= 3'h0;
			elapsed_ff <= 16'h0000;
		end else if (show_ff && ms_tick) begin
			if (step_cnt_ff == 3'(OFF_STEP_MS - 1)) begin
				step_cnt_ff <= 3'h0;
				elapsed_ff <= elapsed_ff + 16'(OFF_STEP_MS);
				// nearest 5 ms step; settings below 3 ms round to zero and mean always on
				if (off_delay_ff >= 16'(OFF_ROUND_MS) &&
				    ({1'b0, elapsed_ff} + 17'(OFF_STEP_MS + OFF_ROUND_MS)) >
				    {1'b0, off_delay_ff}) begin
					show_ff <= 1'b0; // [R18]
				end
			end else begin
				step_cnt_ff <= step_cnt_ff + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// output drivers
	// ----------------------------------------
	// blank while moving: only an arrived position is reported
	assign indicate = valid_ff && !err_ff && show_ff && (st_ff != ST_MOVE); // [R5] [R20]
	// mode never enters here, so outputs behave alike in every mode
	always_ff @(posedge pclk or negedge presetn) begin // [R9]
		if (!presetn) begin
			pos_a_n_ff <= 1'b1;
			pos_b_n_ff <= 1'b1;
			rel_a_n_ff <= 1'b1;
			rel_b_n_ff <= 1'b1;
		end else begin
			pos_a_n_ff <= ~(indicate && !pos_b_ff); // [R2] [R4]
			rel_a_n_ff <= ~(indicate && !pos_b_ff); // [R2]
			pos_b_n_ff <= ~(indicate && pos_b_ff); // [R3] [R4]
			rel_b_n_ff <= ~(indicate && pos_b_ff); // [R3]
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_ff.pready;
	assign rd_setup = apb_req.psel && !apb_req.penable;
	always_comb begin
		status = 32'h0000_0000;
		status[ST_POS_B_BIT] = pos_b_ff;
		status[ST_VALID_BIT] = valid_ff;
		status[ST_ERR_BIT] = err_ff;
		status[ST_BUSY_BIT] = (st_ff != ST_IDLE);
		status[ST_IN1_BIT] = asrt[0];
		status[ST_IN2_BIT] = asrt[1];
		status[ST_SHOW_BIT] = indicate;
	end
	// answer in the first cycle of the access phase, registered from setup; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.pready <= rd_setup;
			if (rd_setup) begin
				rsp_ff.pslverr <= 1'b0;
				rsp_ff.prdata <= 32'h0000_0000;
				if (apb_req.paddr == MODE_OFF) begin
					rsp_ff.prdata <= {29'h0, mode_ff};
				end else if (apb_req.paddr == RET_DELAY_OFF) begin
					rsp_ff.prdata <= {16'h0000, ret_delay_ff};
				end else if (apb_req.paddr == OFF_DELAY_OFF) begin
					rsp_ff.prdata <= {16'h0000, off_delay_ff};
				end else if (apb_req.paddr == STATUS_OFF) begin
					rsp_ff.prdata <= apb_req.pwrite ? 32'h0000_0000 : status;
				end else begin
					rsp_ff.pslverr <= 1'b1;
				end
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= MODE_RST; // [R8]
			ret_delay_ff <= RET_DELAY_RST; // [R13]
			off_delay_ff <= OFF_DELAY_RST; // [R18]
		end else if (wr_acc) begin
			if (apb_req.paddr == MODE_OFF) begin
				// out-of-range modes are dropped, old mode stays
				if (apb_req.pwdata[2:0] >= MODE_MIN && apb_req.pwdata[2:0] <= MODE_MAX &&
				    apb_req.pwdata[31:3] == 29'h0) begin
					mode_ff <= apb_req.pwdata[2:0]; // [R8]
				end
			end else if (apb_req.paddr == RET_DELAY_OFF) begin
				ret_delay_ff <= apb_req.pwdata[15:0]; // [R17]
			end else if (apb_req.paddr == OFF_DELAY_OFF) begin
				if (apb_req.pwdata[15:0] > OFF_DELAY_MAX_MS || apb_req.pwdata[31:16] != 16'h0) begin
					off_delay_ff <= OFF_DELAY_MAX_MS; // [R18]
				end else begin
					off_delay_ff <= apb_req.pwdata[15:0]; // [R18]
				end
			end
		end
	end
	assign apb_rsp = rsp_ff;
	assign move_req = move_req_ff;
	assign move_to_b = target_b_ff;
	assign pos_a_out_n = pos_a_n_ff;
	assign pos_b_out_n = pos_b_n_ff;
	assign relay_a_close_n = rel_a_n_ff;
	assign relay_b_close_n = rel_b_n_ff;
endmodule

// ---- testbench/valve_io_asserts.sv ----
module valve_io_asserts
	import valve_io_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bus, motor and indication
	input wire apb_req_t apb_req,
	input wire apb_rsp_t apb_rsp,
	input wire logic move_req,
	input wire logic move_to_b,
	input wire logic move_done,
	input wire logic move_fault,
	input wire logic pos_a_out_n,
	input wire logic pos_b_out_n,
	input wire logic relay_a_close_n,
	input wire logic relay_b_close_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// helpers
	// ----
	logic moving_ff;
	wire logic a_set = !pos_a_out_n || !relay_a_close_n;
	wire logic b_set = !pos_b_out_n || !relay_b_close_n;
	wire logic all_off = !a_set && !b_set;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			moving_ff <= 1'b0;
		end else if (move_req) begin
			moving_ff <= 1'b1;
		end else if (move_done || move_fault) begin
			moving_ff <= 1'b0;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_blank;
		all_off [*2];
	endsequence
	AST_EXCL: assert property (!(a_set && b_set))
		else $error("both indication sets on");
	AST_SET_A: assert property (a_set |->
		!pos_a_out_n && !relay_a_close_n && !$past(move_to_b))
		else $error("A indication incomplete");
	AST_SET_B: assert property (b_set |->
		!pos_b_out_n && !relay_b_close_n && $past(move_to_b))
		else $error("B indication incomplete");
	AST_FAULT_OFF: assert property (move_fault && moving_ff |=> all_off [*6])
		else $error("indication on after fault");
	AST_BLANK: assert property (move_req |=> s_blank)
		else $error("indication on during move");
	AST_TARGET: assert property ($changed(move_to_b) |-> move_req)
		else $error("target changed without request");
	AST_NO_BUSY_REQ: assert property (moving_ff |-> !move_req)
		else $error("request while moving");
	AST_READY: assert property (s_setup |=> apb_rsp.pready)
		else $error("no ready after setup");
	AST_ERR: assert property (apb_rsp.pready |->
		apb_rsp.pslverr == (apb_req.paddr > STATUS_OFF))
		else $error("slave error mismatch");
endmodule

bind valve_position_discrete_io valve_io_asserts valve_io_asserts_inst (
	.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.move_req(move_req), .move_to_b(move_to_b), .move_done(move_done),
	.move_fault(move_fault), .pos_a_out_n(pos_a_out_n), .pos_b_out_n(pos_b_out_n),
	.relay_a_close_n(relay_a_close_n), .relay_b_close_n(relay_b_close_n));

// ---- testbench/valve_io_partner.sv ----
module valve_io_partner (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// motor handshake
	input wire logic move_req,
	output logic move_done,
	output logic move_fault,
	// command pins, pulled up when idle
	output logic cmd_in1_n = 1'b1,
	output logic cmd_in2_n = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	int lat = 3;
	int cnt;
	logic fail = 1'b0;
	// callers hold each level past the filter time, except on purpose
	task pins(input logic a, input logic b, input int hold);
		@(posedge pclk);
		cmd_in1_n <= a;
		cmd_in2_n <= b;
		repeat (hold) @(posedge pclk);
	endtask
	// lat of 3 or more, as a real motor never finishes at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			move_done <= 1'b0;
			move_fault <= 1'b0;
		end else begin
			move_done <= 1'b0;
			move_fault <= 1'b0;
			if (move_req) begin
				cnt <= lat;
			end else if (cnt == 1) begin
				move_done <= !fail;
				move_fault <= fail;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// ---- testbench/valve_position_discrete_io_test.sv ----
`define CHK(a, b) begin \
	n_checks++; \
	if ((a) !== (b)) begin \
		fails++; \
		$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); \
	end \
end
module valve_position_discrete_io_test;
	import valve_io_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int L = 40;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic in1_n, in2_n, mreq, mtob, mdone, mfault, pa_n, pb_n, ra_n, rb_n, e;
	logic exp_q[$];
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	always #10 pclk = ~pclk;
	valve_position_discrete_io #(.STABLE_CYC(20), .MS_CYC(10), .FILT_W(21), .TICK_W(16))
		valve_position_discrete_io_inst (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .cmd_in1_n(in1_n), .cmd_in2_n(in2_n), .move_req(mreq),
		.move_to_b(mtob), .move_done(mdone), .move_fault(mfault), .pos_a_out_n(pa_n),
		.pos_b_out_n(pb_n), .relay_a_close_n(ra_n), .relay_b_close_n(rb_n));
	valve_io_partner valve_io_partner_inst (.pclk(pclk), .presetn(presetn),
		.move_req(mreq), .move_done(mdone), .move_fault(mfault),
		.cmd_in1_n(in1_n), .cmd_in2_n(in2_n));
	// ----
	// tasks
	// ----
	task end_sim;
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		err = rsp.pslverr;
		`CHK(rsp.pready, 1'b1)
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic err;
		apb(1'b1, a, d, q, err);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic err;
		apb(1'b0, a, 32'h0, q, err);
		`CHK(q, x)
		`CHK(err, xe)
	endtask
	task chk_out(input int p);
		logic [3:0] x;
		x = (p == 0) ? 4'h3 : (p == 1) ? 4'hC : 4'hF;
		`CHK({pa_n, ra_n, pb_n, rb_n}, x)
	endtask
	task push(input logic t);
		exp_q.push_back(t);
		valve_io_partner_inst.lat = 3 + $urandom_range(7);
	endtask
	task drive(input logic a, input logic b, input int h);
		valve_io_partner_inst.pins(a, b, h);
	endtask
	// every request is matched against the model queue
	always @(posedge pclk) begin
		cyc++;
		if (mreq === 1'b1) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : !mtob;
			`CHK(mtob, e)
		end
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		void'($urandom(25441));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(MODE_OFF, {29'h0, MODE_RST}, 1'b0);
		rd(RET_DELAY_OFF, {16'h0, RET_DELAY_RST}, 1'b0);
		rd(OFF_DELAY_OFF, {16'h0, OFF_DELAY_RST}, 1'b0);
		rd(12'h010, 32'h0, 1'b1);
		wr(MODE_OFF, 32'h5);
		rd(MODE_OFF, 32'h1, 1'b0);
		wr(OFF_DELAY_OFF, 32'h9C40);
		rd(OFF_DELAY_OFF, {16'h0, OFF_DELAY_MAX_MS}, 1'b0);
		wr(OFF_DELAY_OFF, 32'h0);
		chk_out(2);
		push(1'b0);
		drive(0, 1, L);
		drive(1, 1, L);
		chk_out(0);
		push(1'b1);
		drive(1, 0, L);
		drive(1, 1, L);
		chk_out(1);
		drive(0, 0, L);
		drive(1, 1, L);
		chk_out(1);
		drive(0, 1, 8);
		drive(1, 1, L);
		chk_out(1);
		wr(RET_DELAY_OFF, 32'h3);
		rd(RET_DELAY_OFF, 32'h3, 1'b0);
		wr(MODE_OFF, {29'h0, MODE_TOGGLE});
		chk_out(1);
		push(1'b0);
		drive(0, 1, 3 * L);
		drive(1, 1, L);
		chk_out(0);
		push(1'b1);
		push(1'b0);
		drive(1, 0, L);
		chk_out(1);
		drive(1, 1, 2 * L);
		chk_out(0);
		wr(MODE_OFF, 32'h1);
		valve_io_partner_inst.fail = 1'b1;
		push(1'b1);
		drive(1, 0, L);
		drive(1, 1, L);
		chk_out(2);
		rd(STATUS_OFF, 32'h1 << ST_ERR_BIT, 1'b0);
		valve_io_partner_inst.fail = 1'b0;
		push(1'b0);
		drive(0, 1, L);
		drive(1, 1, L);
		chk_out(0);
		rd(STATUS_OFF, (32'h1 << ST_VALID_BIT) | (32'h1 << ST_SHOW_BIT), 1'b0);
		wr(MODE_OFF, 32'h3);
		drive(0, 1, L);
		drive(1, 1, L);
		chk_out(0);
		push(1'b1);
		drive(1, 0, L);
		chk_out(1);
		push(1'b0);
		drive(0, 0, L);
		chk_out(0);
		wr(MODE_OFF, 32'h4);
		drive(1, 0, L);
		chk_out(0);
		push(1'b1);
		drive(1, 1, L);
		chk_out(1);
		wr(OFF_DELAY_OFF, 32'hA);
		push(1'b0);
		drive(0, 1, 60);
		chk_out(0);
		repeat (100) @(posedge pclk);
		chk_out(2);
		`CHK(exp_q.size(), 0)
		end_sim();
	end
endmodule
